/* rtl/trw_defs.svh */
`ifndef TRW_DEFS_SVH
`define TRW_DEFS_SVH
// ==========================================
// register byte offsets
`define TRW_OFS_CTRL 12'h000
`define TRW_OFS_MODE 12'h004
`define TRW_OFS_PRE 12'h008
`define TRW_OFS_PRD 12'h00c
`define TRW_OFS_INT 12'h010
// ==========================================
// field positions
`define TRW_CTRL_START 0
`define TRW_CTRL_STATUS 1
`define TRW_CTRL_STOP 2
`define TRW_MODE_WTS 3
`define TRW_MODE_SRC_LO 4
`define TRW_MODE_SRC_HI 5
`define TRW_INT_IRQ 3
// ==========================================
// reset values and timing counts
`define TRW_RST_PRE 8'hff
`define TRW_RST_PRD 8'hff
`define TRW_F8_LAST 3'h7
`endif

/* rtl/trw_pkg.sv */
package trw_pkg;
   typedef enum logic [1:0] {
      TRW_SRC_F1 = 2'b00,
      TRW_SRC_F2 = 2'b01,
      TRW_SRC_F8 = 2'b10,
      TRW_SRC_EXT = 2'b11
   } trw_src_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic start;
      logic status;
      logic wts;
      trw_src_t src;
      logic [7:0] pre_rld;
      logic [7:0] pre_cnt;
      logic [7:0] pre_new;
      logic pre_pend;
      logic pre_both;
      logic pre_ld;
      logic [7:0] tmr_rld;
      logic [7:0] tmr_cnt;
      logic [7:0] tmr_new;
      logic tmr_pend;
      logic tmr_both;
      logic tmr_ld;
      logic irq;
      logic uf;
      logic [2:0] div;
      logic [2:0] sync;
      logic ext_lvl;
   } trw_state_t;
endpackage

/* rtl/trw_timer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trw_defs.svh"
module trw_timer (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic EXT_TICK,
   output logic PREADY,
   output logic PSLVERR,
   output logic [31:0] PRDATA,
   output logic IRQ_FLAG,
   output logic UNDERFLOW
);
   import trw_pkg::*;

   // ==========================================
   // state and decode
   trw_state_t r;
   trw_state_t next_r;
   logic running;
   logic tick;
   logic pre_uf;
   logic tmr_uf;
   logic wr;
   logic rd_setup;
   logic wr_pre;
   logic wr_tmr;
   logic ext_rise;
   logic hit;
   logic [31:0] rdata;

   assign running = r.start & r.status;
   assign wr = PSEL & PENABLE & r.pready & PWRITE;
   assign rd_setup = PSEL & ~PENABLE & ~r.pready;
   assign wr_pre = wr && (PADDR == `TRW_OFS_PRE);
   assign wr_tmr = wr && (PADDR == `TRW_OFS_PRD);
   assign ext_rise = (r.sync[1] == r.sync[2]) && r.sync[2] && !r.ext_lvl;

   // ==========================================
   // count source select
   always_comb begin
      case (r.src)
         TRW_SRC_F1: tick = 1'b1;
         TRW_SRC_F2: tick = r.div[0];
         TRW_SRC_F8: tick = (r.div == `TRW_F8_LAST);
         default: tick = ext_rise;
      endcase
   end

   // prescaler underflow: count reaches zero and no pending counter load
   assign pre_uf = running && tick && !r.pre_ld && (r.pre_cnt == 8'h00);
   assign tmr_uf = pre_uf && !r.tmr_ld && (r.tmr_cnt == 8'h00);

   // ==========================================
   // read mux
   always_comb begin
      hit = 1'b1;
      rdata = 32'h0000_0000;
      if (PADDR == `TRW_OFS_CTRL) begin
         rdata[`TRW_CTRL_START] = r.start;
         rdata[`TRW_CTRL_STATUS] = r.status;
      end else if (PADDR == `TRW_OFS_MODE) begin
         rdata[`TRW_MODE_WTS] = r.wts;
         rdata[`TRW_MODE_SRC_HI:`TRW_MODE_SRC_LO] = r.src;
      end else if (PADDR == `TRW_OFS_PRE) begin
         rdata[7:0] = r.pre_cnt;
      end else if (PADDR == `TRW_OFS_PRD) begin
         rdata[7:0] = r.tmr_cnt;
      end else if (PADDR == `TRW_OFS_INT) begin
         rdata[`TRW_INT_IRQ] = r.irq;
      end else begin
         hit = 1'b0;
      end
   end

   // ==========================================
   // next state
   always_comb begin
      next_r = r;
      next_r.uf = 1'b0;
      // apb handshake: one wait-free access phase
      next_r.pready = rd_setup;
      if (rd_setup) begin
         next_r.prdata = PWRITE ? 32'h0000_0000 : rdata;
         next_r.pslverr = ~hit;
      end
      // pin synchroniser and clock divider
      next_r.sync = {r.sync[1:0], EXT_TICK};
      if (r.sync[1] == r.sync[2]) begin
         next_r.ext_lvl = r.sync[2];
      end
      next_r.div = r.div + 3'h1;
      // status follows start in step with the count source
      if (tick) begin
         next_r.status = r.start;
      end
      // prescaler stage; capture after load so a newer pending load is kept
      if (running && tick) begin
         if (r.pre_ld) begin
            next_r.pre_cnt = r.pre_rld;
            next_r.pre_ld = 1'b0;
         end else if (r.pre_cnt == 8'h00) begin
            next_r.pre_cnt = r.pre_rld;
         end else begin
            next_r.pre_cnt = r.pre_cnt - 8'h01;
         end
         if (r.pre_pend) begin
            next_r.pre_rld = r.pre_new;
            next_r.pre_pend = 1'b0;
            next_r.pre_ld = r.pre_both;
         end
      end
      // timer stage counts prescaler underflows
      if (pre_uf) begin
         if (r.tmr_ld) begin
            next_r.tmr_cnt = r.tmr_rld;
            next_r.tmr_ld = 1'b0;
         end else if (r.tmr_cnt == 8'h00) begin
            next_r.tmr_cnt = r.tmr_rld;
         end else begin
            next_r.tmr_cnt = r.tmr_cnt - 8'h01;
         end
         if (r.tmr_pend) begin
            next_r.tmr_rld = r.tmr_new;
            next_r.tmr_pend = 1'b0;
            next_r.tmr_ld = r.tmr_both;
         end
      end
      // software writes
      if (wr && (PADDR == `TRW_OFS_CTRL)) begin
         next_r.start = PWDATA[`TRW_CTRL_START];
         if (PWDATA[`TRW_CTRL_STOP]) begin
            next_r.start = 1'b0;
            next_r.status = 1'b0;
         end
      end
      if (wr && (PADDR == `TRW_OFS_MODE)) begin
         next_r.wts = PWDATA[`TRW_MODE_WTS];
         next_r.src = trw_src_t'(PWDATA[`TRW_MODE_SRC_HI:`TRW_MODE_SRC_LO]);
      end
      if (wr_pre) begin
         if (running) begin
            next_r.pre_new = PWDATA[7:0];
            next_r.pre_pend = 1'b1;
            next_r.pre_both = ~r.wts;
         end else begin
            next_r.pre_rld = PWDATA[7:0];
            next_r.pre_cnt = PWDATA[7:0];
            next_r.pre_pend = 1'b0;
            next_r.pre_ld = 1'b0;
         end
      end
      if (wr_tmr) begin
         if (running) begin
            next_r.tmr_new = PWDATA[7:0];
            next_r.tmr_pend = 1'b1;
            next_r.tmr_both = ~r.wts;
         end else begin
            next_r.tmr_rld = PWDATA[7:0];
            next_r.tmr_cnt = PWDATA[7:0];
            next_r.tmr_pend = 1'b0;
            next_r.tmr_ld = 1'b0;
         end
      end
      // flag clears by writing 0; an underflow in that cycle wins
      if (wr && (PADDR == `TRW_OFS_INT) && !PWDATA[`TRW_INT_IRQ]) begin
         next_r.irq = 1'b0;
      end
      if (tmr_uf) begin
         next_r.irq = 1'b1;
         next_r.uf = 1'b1;
      end
      if (!CE) begin
         next_r = r;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         r <= '0;
         r.pre_rld <= `TRW_RST_PRE;
         r.pre_cnt <= `TRW_RST_PRE;
         r.tmr_rld <= `TRW_RST_PRD;
         r.tmr_cnt <= `TRW_RST_PRD;
      end else begin
         r <= next_r;
      end
   end

   assign PREADY = r.pready;
   assign PSLVERR = r.pslverr;
   assign PRDATA = r.prdata;
   assign IRQ_FLAG = r.irq;
   assign UNDERFLOW = r.uf;

   // ==========================================
   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   a_irq_on_uf: assert property (CE && tmr_uf |=> r.irq && r.uf)
      else $error("flag not set on timer underflow");
   a_irq_cause: assert property ($rose(r.irq) |-> $past(tmr_uf) && $past(CE))
      else $error("flag set without timer underflow");
   a_running_def: assert property (running == (r.start && r.status))
      else $error("running differs from start and status");
   a_no_imm_load: assert property (CE && wr_pre && running && !tick |=>
      r.pre_cnt == $past(r.pre_cnt) && r.pre_pend)
      else $error("prescaler counter changed on running write");
   a_pre_capture: assert property (CE && running && tick && r.pre_pend && !wr_pre |=>
      r.pre_rld == $past(r.pre_new))
      else $error("prescaler reload not captured on tick");
   a_tmr_capture: assert property (CE && pre_uf && r.tmr_pend && !wr_tmr |=>
      r.tmr_rld == $past(r.tmr_new))
      else $error("timer reload not captured on underflow");
   a_stop_write: assert property (CE && wr_pre && !running |=>
      r.pre_cnt == $past(PWDATA[7:0]) && r.pre_rld == $past(PWDATA[7:0]))
      else $error("stopped write missed reload or counter");
   a_pre_wrap: assert property (CE && pre_uf && !wr_pre |=>
      r.pre_cnt == $past(r.pre_rld))
      else $error("prescaler did not reload on underflow");
   a_tmr_hold: assert property (CE && !pre_uf && !wr_tmr |=> $stable(r.tmr_cnt))
      else $error("timer counter moved without prescaler underflow");
   a_both_load: assert property (CE && running && tick && r.pre_ld && !wr_pre |=>
      r.pre_cnt == $past(r.pre_rld))
      else $error("pending counter load not applied on tick");
   a_read_live: assert property (CE && rd_setup && !PWRITE && PADDR == `TRW_OFS_PRE |=>
      r.prdata[7:0] == $past(r.pre_cnt))
      else $error("prescaler read did not return counter");

   // ==========================================
   // bus handshake checks
   a_pready_pulse: assert property (CE && r.pready |=>
      !r.pready)
      else $error("ready held longer than one cycle");

   a_pready_setup: assert property (CE && rd_setup |=>
      r.pready)
      else $error("ready missing after setup");

   a_slverr_unmapped: assert property (CE && rd_setup && !hit |=>
      r.pslverr)
      else $error("error missing on unmapped access");

   a_slverr_mapped: assert property (CE && rd_setup && hit |=>
      !r.pslverr)
      else $error("error raised on mapped access");

   a_read_tmr: assert property (CE && rd_setup && !PWRITE && PADDR == `TRW_OFS_PRD |=>
      r.prdata[7:0] == $past(r.tmr_cnt))
      else $error("timer read did not return counter");

   // ==========================================
   // counting checks
   a_pre_step: assert property (CE && running && tick && !r.pre_ld && r.pre_cnt != 8'h00 &&
      !wr_pre |=> r.pre_cnt == $past(r.pre_cnt) - 8'h01)
      else $error("prescaler did not decrement");

   a_pre_hold: assert property (CE && !(running && tick) && !wr_pre |=>
      $stable(r.pre_cnt))
      else $error("prescaler moved without count tick");

   a_tmr_step: assert property (CE && pre_uf && !r.tmr_ld && r.tmr_cnt != 8'h00 &&
      !wr_tmr |=> r.tmr_cnt == $past(r.tmr_cnt) - 8'h01)
      else $error("timer did not step on prescaler underflow");

   a_tmr_wrap: assert property (CE && tmr_uf && !wr_tmr |=>
      r.tmr_cnt == $past(r.tmr_rld))
      else $error("timer did not reload on underflow");

   a_tmr_load: assert property (CE && pre_uf && r.tmr_ld && !wr_tmr |=>
      r.tmr_cnt == $past(r.tmr_rld))
      else $error("pending timer load not applied");

   a_tmr_no_imm: assert property (CE && wr_tmr && running && !pre_uf |=>
      r.tmr_cnt == $past(r.tmr_cnt) && r.tmr_pend)
      else $error("timer counter changed on running write");

   a_only_reload: assert property (CE && pre_uf && r.tmr_pend && !r.tmr_both &&
      !r.tmr_ld && r.tmr_cnt != 8'h00 && !wr_tmr |=> r.tmr_cnt == $past(r.tmr_cnt) - 8'h01)
      else $error("reload-only write disturbed timer count");

   a_tmr_both_arm: assert property (CE && pre_uf && r.tmr_pend && r.tmr_both && !wr_tmr |=>
      r.tmr_ld)
      else $error("timer counter load not armed");

   a_pre_both_arm: assert property (CE && running && tick && r.pre_pend && r.pre_both &&
      !wr_pre |=> r.pre_ld)
      else $error("prescaler counter load not armed");

   a_pre_ld_done: assert property (CE && running && tick && r.pre_ld && !r.pre_pend &&
      !wr_pre |=> !r.pre_ld)
      else $error("prescaler load left pending");

   a_stop_tmr_write: assert property (CE && wr_tmr && !running |=>
      r.tmr_cnt == $past(PWDATA[7:0]) && r.tmr_rld == $past(PWDATA[7:0]))
      else $error("stopped timer write missed reload or counter");

   // ==========================================
   // control and flag checks
   a_status_follow: assert property (CE && tick && !wr |=>
      r.status == $past(r.start))
      else $error("status did not follow start on tick");

   a_stop_clears: assert property (CE && wr && PADDR == `TRW_OFS_CTRL &&
      PWDATA[`TRW_CTRL_STOP] |=> !r.start && !r.status)
      else $error("forced stop left counting on");

   a_flag_hold: assert property (CE && !tmr_uf && !(wr && PADDR == `TRW_OFS_INT) |=>
      $stable(r.irq))
      else $error("flag changed without cause");

   a_flag_clear: assert property (CE && wr && PADDR == `TRW_OFS_INT &&
      !PWDATA[`TRW_INT_IRQ] && !tmr_uf |=> !r.irq)
      else $error("flag not cleared by write");

   a_uf_cause: assert property ($rose(r.uf) |->
      $past(tmr_uf))
      else $error("underflow pulse without timer underflow");

   a_freeze: assert property (!CE |=>
      $stable(r))
      else $error("state moved while clock enable low");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "trw_defs.svh"
module tb_top;
   logic clk, rst_b, psel, penable, pwrite, err;
   logic ext_tick = 1'b0;
   logic pready, pslverr, irq_flag, underflow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic [7:0] n, m;
   int failures = 0;
   int check_count = 0;
   int cycles = 0;
   int p;

   trw_timer u_dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .EXT_TICK(ext_tick),
      .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata), .IRQ_FLAG(irq_flag),
      .UNDERFLOW(underflow));

   // ==========================================
   // clock, external tick, timeout
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles % 4 == 0) ext_tick <= ~ext_tick;
      if (cycles == 20000) begin
         failures = failures + 1;
         tally_and_finish();
      end
   end

   // ==========================================
   // helpers
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic int exp_period(input int s, input logic [7:0] pn, pm);
      int dv;
      dv = (s == 0) ? 1 : (s == 1) ? 2 : 8;
      return dv * (pn + 1) * (pm + 1);
   endfunction

   task automatic chk(input logic [31:0] got, exp, input string what);
      check_count = check_count + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      logic done;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      done = 1'b0;
      while (!done) begin
         // settled value here is what the next rising edge samples
         @(negedge clk);
         done = (pready === 1'b1);
         rd = prdata;
         err = pslverr;
         @(posedge clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_uf(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (underflow !== 1'b1 && c < 5000);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      lfsr = 32'h000104ba;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, `TRW_OFS_PRE, 32'h0);
      chk(rd, 32'h000000ff, "pre reset");
      apb(1'b0, `TRW_OFS_PRD, 32'h0);
      chk(rd, 32'h000000ff, "prd reset");
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         lfsr = next_rand(lfsr);
         n = {6'h00, lfsr[1:0]} + 8'h01;
         m = {6'h00, lfsr[3:2]};
         apb(1'b1, `TRW_OFS_MODE, 32'(s) << 4);
         apb(1'b1, `TRW_OFS_PRE, {24'h0, n});
         apb(1'b1, `TRW_OFS_PRD, {24'h0, m});
         apb(1'b0, `TRW_OFS_PRE, 32'h0);
         chk(rd, {24'h0, n}, "stopped write");
         apb(1'b1, `TRW_OFS_CTRL, 32'h1);
         wait_uf(p);
         wait_uf(p);
         chk(p, exp_period(s, n, m), "underflow period");
         apb(1'b0, `TRW_OFS_CTRL, 32'h0);
         chk({30'h0, rd[1:0]}, 32'h3, "running status");
         apb(1'b0, `TRW_OFS_INT, 32'h0);
         chk({31'h0, rd[3]}, 32'h1, "flag set");
         apb(1'b1, `TRW_OFS_CTRL, 32'h4);
         apb(1'b1, `TRW_OFS_INT, 32'h0);
         apb(1'b0, `TRW_OFS_INT, 32'h0);
         chk({31'h0, rd[3]}, 32'h0, "flag cleared");
         $display("test source %0d done", s);
      end
      for (int w = 0; w < 2; w++) begin
         apb(1'b1, `TRW_OFS_MODE, 32'(w) << 3);
         apb(1'b1, `TRW_OFS_PRE, 32'h1);
         apb(1'b1, `TRW_OFS_PRD, 32'hff);
         apb(1'b1, `TRW_OFS_CTRL, 32'h1);
         repeat (5) @(posedge clk);
         apb(1'b0, `TRW_OFS_PRD, 32'h0);
         chk({31'h0, rd[7:0] == 8'hff}, 32'h0, "live count read");
         apb(1'b1, `TRW_OFS_PRD, 32'h2);
         wait_uf(p);
         chk({31'h0, p < 40}, {31'h0, w == 0}, "write target");
         wait_uf(p);
         chk(p, 6, "new period");
         apb(1'b1, `TRW_OFS_CTRL, 32'h4);
         $display("test select %0d done", w);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
